// [logic/sctrl_pkg.sv]
// Summary of operation
// - Control bit 0 enables transmit, resets 0
// - Bit 1 reads 1 when transmit buffer empty
// - Control bit 2 enables receive, resets 0
// - Bit 3 set while receive buffer holds data
// - Receive buffer read clears receive-complete flag
// - Bit 4 picks transmit interrupt source
// - Bit 5 continuous receive; bits 6-7 unassigned
// - Receive word: data 0-8, bits 9-11 undefined
// - Overrun bit 12, framing 13, parity 14
// - Bit 15 is OR of three error flags
// - Mode 000 or receive disable clears errors
// - Buffer read clears parity and framing only
// - Synchronous mode: framing, parity, sum undefined
// - Mode codes: off, sync, async 7/8/9
// - Shift-empty flag 1 when transmission completed
package sctrl_pkg;
   localparam int SCTRL_CH = 2;
   localparam int RX_W = 9;
   // Printed offsets are register indices; byte address = index * 4
   localparam logic [9:0] IDX_MR_0 = 10'h0A0;
   localparam logic [9:0] IDX_TB_0 = 10'h0A2;
   localparam logic [9:0] IDX_C0_0 = 10'h0A4;
   localparam logic [9:0] IDX_C1_0 = 10'h0A5;
   localparam logic [9:0] IDX_RB_0 = 10'h0A6;
   localparam logic [9:0] IDX_MR_1 = 10'h160;
   localparam logic [9:0] IDX_TB_1 = 10'h162;
   localparam logic [9:0] IDX_C0_1 = 10'h164;
   localparam logic [9:0] IDX_C1_1 = 10'h165;
   localparam logic [9:0] IDX_RB_1 = 10'h166;
   localparam int C1_TE = 0;
   localparam int C1_TI = 1;
   localparam int C1_RE = 2;
   localparam int C1_RI = 3;
   localparam int C1_IRS = 4;
   localparam int C1_RRM = 5;
   localparam int C0_TX_SHIFT_EMPTY_FLAG = 3;
   localparam int RB_OER = 12;
   localparam int RB_FER = 13;
   localparam int RB_PER = 14;
   localparam int RB_SUM = 15;
   localparam logic [7:0] C1_RESET = 8'h02;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SYNC = 3'h1;
   localparam logic [2:0] MODE_ASYNC7 = 3'h4;
   localparam logic [2:0] MODE_ASYNC8 = 3'h5;
   localparam logic [2:0] MODE_ASYNC9 = 3'h6;
   typedef enum logic [2:0] {K_NONE, K_MR, K_TB, K_C0, K_C1, K_RB}
      sctrl_kind_type;
   typedef struct packed {
      sctrl_kind_type kind;
      logic ch;
   } sctrl_sel_type;
   typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} sctrl_state_type;
endpackage : sctrl_pkg

// [logic/sctrl_rx_if.sv]
`timescale 1ns/1ns
interface sctrl_rx_if;
   import sctrl_pkg::*;
   logic rx_done;
   logic [RX_W-1:0] rx_data;
   logic rx_fer;
   logic rx_per;
   logic rd_strobe;
   logic err_clear;
   logic sync_mode;
   logic full;
   logic [15:0] rb_word;
   modport ctrl (output rx_done, rx_data, rx_fer, rx_per, rd_strobe,
      err_clear, sync_mode, input full, rb_word);
   modport store (input rx_done, rx_data, rx_fer, rx_per, rd_strobe,
      err_clear, sync_mode, output full, rb_word);
endinterface : sctrl_rx_if

// [logic/sctrl_rxbuf.sv]
`timescale 1ns/1ns
module sctrl_rxbuf
   import sctrl_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   sctrl_rx_if.store rx
);
   logic [RX_W-1:0] data_ff;
   logic full_ff;
   logic oer_ff;
   logic fer_ff;
   logic per_ff;
   logic take;

   // Old word is kept on overrun; a read in the same cycle frees it
   assign take = rx.rx_done & (~full_ff | rx.rd_strobe);

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         data_ff <= '0;
         full_ff <= 1'b0;
      end
      else if (take)
      begin
         data_ff <= rx.rx_data;
         full_ff <= 1'b1;
      end
      else if (rx.rd_strobe)
         full_ff <= 1'b0;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         oer_ff <= 1'b0;
      else if (rx.rx_done & full_ff & ~rx.rd_strobe)
         oer_ff <= 1'b1;
      else if (rx.err_clear)
         oer_ff <= 1'b0;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         fer_ff <= 1'b0;
         per_ff <= 1'b0;
      end
      else if (take)
      begin
         fer_ff <= rx.rx_fer;
         per_ff <= rx.rx_per;
      end
      else if (rx.err_clear | rx.rd_strobe)
      begin
         fer_ff <= 1'b0;
         per_ff <= 1'b0;
      end
   end

   assign rx.full = full_ff;
   always_comb
   begin
      rx.rb_word = '0;
      rx.rb_word[RX_W-1:0] = data_ff;
      rx.rb_word[RB_OER] = oer_ff;
      // Sync mode: framing, parity and sum carry no meaning, read 0
      if (!rx.sync_mode)
      begin
         rx.rb_word[RB_FER] = fer_ff;
         rx.rb_word[RB_PER] = per_ff;
         rx.rb_word[RB_SUM] = oer_ff | fer_ff | per_ff;
      end
   end

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   rd_clears_a: assert property (rx.rd_strobe && !rx.rx_done |=>
      !full_ff && !fer_ff && !per_ff && oer_ff == $past(oer_ff))
      else $error("read did not clear flags");
   overrun_set_a: assert property
      (rx.rx_done && full_ff && !rx.rd_strobe |=>
      oer_ff && data_ff == $past(data_ff))
      else $error("overrun not flagged");
   err_clear_a: assert property (rx.err_clear && !rx.rx_done |=>
      rx.rb_word[RB_SUM:RB_OER] == 4'h0)
      else $error("errors not cleared");
   sum_or_a: assert property (!rx.sync_mode |->
      rx.rb_word[RB_SUM] == |rx.rb_word[RB_PER:RB_OER])
      else $error("sum flag wrong");
   rx_full_a: assert property (rx.rx_done |=> full_ff)
      else $error("complete flag not set");
endmodule : sctrl_rxbuf

// [logic/sctrl_irq_edge.sv]
`timescale 1ns/1ns
module sctrl_irq_edge (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic sel_in,
   input wire logic buf_empty_in,
   input wire logic shift_empty_in,
   output logic irq_out
);
   logic cond;
   logic prev_ff;
   logic irq_ff;

   assign cond = sel_in ? shift_empty_in : buf_empty_in;
   // Both conditions are 1 out of reset, so no request fires then
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         prev_ff <= 1'b1;
         irq_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= cond;
         irq_ff <= cond & ~prev_ff;
      end
   end
   assign irq_out = irq_ff;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   irq_rise_a: assert property
      (cond && !prev_ff |=> irq_ff ##1 !irq_ff || $rose(cond))
      else $error("request not one pulse on rise");
   irq_cause_a: assert property (irq_ff |-> $past(cond, 1))
      else $error("request without selected condition");
endmodule : sctrl_irq_edge

// [logic/sctrl_top.sv]
`timescale 1ns/1ns
module sctrl_top
   import sctrl_pkg::*;
#(
   parameter int HADDR_W = 12
)
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] eng_rx_done_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0][sctrl_pkg::RX_W-1:0]
      eng_rx_data_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] eng_rx_fer_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] eng_rx_per_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] eng_tx_taken_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] eng_tx_shift_empty_in,
   output logic [sctrl_pkg::SCTRL_CH-1:0] tx_enable_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] rx_enable_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] cont_rx_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0][2:0] serial_mode_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0][sctrl_pkg::RX_W-1:0]
      tx_data_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] tx_buf_empty_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] tx_irq_out
);
   import sctrl_pkg::*;

   if (HADDR_W < 12 || HADDR_W > 32)
   begin : g_bad_width
      $error("HADDR_W must lie between 12 and 32");
   end

   localparam logic [9:0] IDX_MR [SCTRL_CH] = '{IDX_MR_0, IDX_MR_1};
   localparam logic [9:0] IDX_TB [SCTRL_CH] = '{IDX_TB_0, IDX_TB_1};
   localparam logic [9:0] IDX_C0 [SCTRL_CH] = '{IDX_C0_0, IDX_C0_1};
   localparam logic [9:0] IDX_C1 [SCTRL_CH] = '{IDX_C1_0, IDX_C1_1};
   localparam logic [9:0] IDX_RB [SCTRL_CH] = '{IDX_RB_0, IDX_RB_1};

   // Word decode; address bits above the map must be zero
   function automatic sctrl_sel_type reg_decode(input logic [31:0] addr);
      sctrl_sel_type s;
      logic [9:0] idx;
      s.kind = K_NONE;
      s.ch = 1'b0;
      idx = addr[11:2];
      if (addr[31:12] == 20'h0)
      begin
         for (int c = 0; c < SCTRL_CH; c++)
         begin
            if (idx == IDX_MR[c])
            begin
               s.kind = K_MR;
               s.ch = c[0];
            end
            if (idx == IDX_TB[c])
            begin
               s.kind = K_TB;
               s.ch = c[0];
            end
            if (idx == IDX_C0[c])
            begin
               s.kind = K_C0;
               s.ch = c[0];
            end
            if (idx == IDX_C1[c])
            begin
               s.kind = K_C1;
               s.ch = c[0];
            end
            if (idx == IDX_RB[c])
            begin
               s.kind = K_RB;
               s.ch = c[0];
            end
         end
      end
      return s;
   endfunction : reg_decode

   sctrl_state_type state_ff;
   sctrl_sel_type sel_ff;
   logic wr_ff;
   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] rd_word;
   logic taken;
   logic do_write;
   logic do_read;

   logic [SCTRL_CH-1:0] te_ff;
   logic [SCTRL_CH-1:0] re_ff;
   logic [SCTRL_CH-1:0] irs_ff;
   logic [SCTRL_CH-1:0] rrm_ff;
   logic [SCTRL_CH-1:0] ti_ff;
   logic [SCTRL_CH-1:0][2:0] mode_ff;
   logic [SCTRL_CH-1:0][RX_W-1:0] tb_ff;
   logic [SCTRL_CH-1:0] rd_rb;
   logic [SCTRL_CH-1:0] err_clr;
   logic [SCTRL_CH-1:0] full;
   logic [SCTRL_CH-1:0][15:0] rb_word;

   sctrl_rx_if rx_bus [SCTRL_CH] ();

   // A write's data only exists in the cycle after its address phase
   assign taken = hsel_in & hready_in & htrans_in[1];
   assign do_write = (state_ff == ST_BUSY) & wr_ff;
   assign do_read = (state_ff == ST_BUSY) & ~wr_ff;

   // One wait state on every transfer keeps write-then-read coherent
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         state_ff <= ST_IDLE;
         hreadyout_ff <= 1'b1;
         wr_ff <= 1'b0;
         sel_ff <= '{kind: K_NONE, ch: 1'b0};
      end
      else
      begin
         unique case (state_ff)
            ST_IDLE:
            begin
               if (taken)
               begin
                  state_ff <= ST_BUSY;
                  hreadyout_ff <= 1'b0;
                  wr_ff <= hwrite_in;
                  sel_ff <= reg_decode(haddr_in);
               end
            end
            ST_BUSY:
            begin
               state_ff <= ST_IDLE;
               hreadyout_ff <= 1'b1;
            end
         endcase
      end
   end

   always_comb
   begin
      rd_word = '0;
      unique case (sel_ff.kind)
         K_MR:
            rd_word[2:0] = mode_ff[sel_ff.ch];
         K_C0:
            rd_word[C0_TX_SHIFT_EMPTY_FLAG] = eng_tx_shift_empty_in[sel_ff.ch];
         K_C1:
         begin
            rd_word[C1_TE] = te_ff[sel_ff.ch];
            rd_word[C1_TI] = ti_ff[sel_ff.ch];
            rd_word[C1_RE] = re_ff[sel_ff.ch];
            rd_word[C1_RI] = full[sel_ff.ch];
            rd_word[C1_IRS] = irs_ff[sel_ff.ch];
            rd_word[C1_RRM] = rrm_ff[sel_ff.ch];
         end
         K_RB:
            rd_word[15:0] = rb_word[sel_ff.ch];
         default:
            rd_word = '0;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         hrdata_ff <= '0;
      else if (do_read)
         hrdata_ff <= rd_word;
   end

   // Enable and option bits of the second control register
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         te_ff <= {SCTRL_CH{C1_RESET[C1_TE]}};
         re_ff <= {SCTRL_CH{C1_RESET[C1_RE]}};
         irs_ff <= {SCTRL_CH{C1_RESET[C1_IRS]}};
         rrm_ff <= {SCTRL_CH{C1_RESET[C1_RRM]}};
      end
      else if (do_write && sel_ff.kind == K_C1)
      begin
         te_ff[sel_ff.ch] <= hwdata_in[C1_TE];
         re_ff[sel_ff.ch] <= hwdata_in[C1_RE];
         irs_ff[sel_ff.ch] <= hwdata_in[C1_IRS];
         // Async mode needs this off; software keeps it so
         rrm_ff[sel_ff.ch] <= hwdata_in[C1_RRM];
      end
   end

   // Codes outside the documented set are stored as written
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         mode_ff <= {SCTRL_CH{MODE_OFF}};
      else if (do_write && sel_ff.kind == K_MR)
         mode_ff[sel_ff.ch] <= hwdata_in[2:0];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         tb_ff <= '0;
      else if (do_write && sel_ff.kind == K_TB)
         tb_ff[sel_ff.ch] <= hwdata_in[RX_W-1:0];
   end

   // Engine take wins over a write landing in the same cycle
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         ti_ff <= {SCTRL_CH{C1_RESET[C1_TI]}};
      else
      begin
         for (int c = 0; c < SCTRL_CH; c++)
         begin
            if (eng_tx_taken_in[c])
               ti_ff[c] <= 1'b1;
            else if (do_write && sel_ff.kind == K_TB && sel_ff.ch == c[0])
               ti_ff[c] <= 1'b0;
         end
      end
   end

   for (genvar g = 0; g < SCTRL_CH; g++)
   begin : g_ch
      // Every word read of the buffer counts as a high-byte read
      assign rd_rb[g] = do_read && sel_ff.kind == K_RB
         && sel_ff.ch == 1'(g);
      assign err_clr[g] = do_write && sel_ff.ch == 1'(g)
         && ((sel_ff.kind == K_MR && hwdata_in[2:0] == MODE_OFF)
         || (sel_ff.kind == K_C1 && !hwdata_in[C1_RE]));
      assign rx_bus[g].rx_done = eng_rx_done_in[g];
      assign rx_bus[g].rx_data = eng_rx_data_in[g];
      assign rx_bus[g].rx_fer = eng_rx_fer_in[g];
      assign rx_bus[g].rx_per = eng_rx_per_in[g];
      assign rx_bus[g].rd_strobe = rd_rb[g];
      assign rx_bus[g].err_clear = err_clr[g];
      assign rx_bus[g].sync_mode = mode_ff[g] == MODE_SYNC;
      assign full[g] = rx_bus[g].full;
      assign rb_word[g] = rx_bus[g].rb_word;

      sctrl_rxbuf u_rxbuf (
         .clk_sys_in(clk_sys_in),
         .rst_n_in(rst_n_in),
         .rx(rx_bus[g].store)
      );

      sctrl_irq_edge u_irq (
         .clk_sys_in(clk_sys_in),
         .rst_n_in(rst_n_in),
         .sel_in(irs_ff[g]),
         .buf_empty_in(ti_ff[g]),
         .shift_empty_in(eng_tx_shift_empty_in[g]),
         .irq_out(tx_irq_out[g])
      );
   end

   assign hrdata_out = hrdata_ff;
   assign hreadyout_out = hreadyout_ff;
   assign hresp_out = 1'b0;
   assign tx_enable_out = te_ff;
   assign rx_enable_out = re_ff;
   assign cont_rx_out = rrm_ff;
   assign serial_mode_out = mode_ff;
   assign tx_data_out = tb_ff;
   assign tx_buf_empty_out = ti_ff;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   bus_wait_a: assert property
      (state_ff == ST_IDLE && taken |=> !hreadyout_ff ##1 hreadyout_ff)
      else $error("wait state not one cycle");
   te_write_a: assert property
      (do_write && sel_ff.kind == K_C1 && !sel_ff.ch |=>
      te_ff[0] == $past(hwdata_in[C1_TE]))
      else $error("transmit enable not stored");
   re_write_a: assert property
      (do_write && sel_ff.kind == K_C1 && sel_ff.ch |=>
      re_ff[1] == $past(hwdata_in[C1_RE]))
      else $error("receive enable not stored");
   ti_write_a: assert property
      (do_write && sel_ff.kind == K_TB && !sel_ff.ch
      && !eng_tx_taken_in[0] |=> !ti_ff[0])
      else $error("buffer flag not cleared by write");
   ti_take_a: assert property (eng_tx_taken_in[1] |=> ti_ff[1])
      else $error("buffer flag not set by take");
   rb_read_a: assert property
      (do_read && sel_ff.kind == K_RB && !sel_ff.ch
      && !eng_rx_done_in[0] |=> !full[0] && hrdata_ff[15:0] ==
      $past(rb_word[0]))
      else $error("buffer read wrong");
   c1_read_a: assert property
      (do_read && sel_ff.kind == K_C1 |=> hrdata_ff[31:6] == '0)
      else $error("unassigned bits not zero");
   tx_shift_empty_flag_read_a: assert property
      (do_read && sel_ff.kind == K_C0 |=>
      hrdata_ff[C0_TX_SHIFT_EMPTY_FLAG] == $past(eng_tx_shift_empty_in[sel_ff.ch]))
      else $error("shift empty flag wrong");
   sync_mask_a: assert property (mode_ff[0] == MODE_SYNC |->
      rb_word[0][RB_SUM:RB_FER] == 3'h0)
      else $error("sync mode flags not masked");

   // Writes must reach the addressed channel and field; read data holds between reads; receive disable clears errors; complete flag reads back
   mode_write_a: assert property
      (do_write && sel_ff.kind == K_MR && !sel_ff.ch |=>
      mode_ff[0] == $past(hwdata_in[2:0]))
      else $error("mode field not stored");
   opt_write_a: assert property
      (do_write && sel_ff.kind == K_C1 && sel_ff.ch |=>
      rrm_ff[1] == $past(hwdata_in[C1_RRM])
      && irs_ff[1] == $past(hwdata_in[C1_IRS]))
      else $error("option bits not stored");
   en_write_a: assert property
      (do_write && sel_ff.kind == K_C1 && sel_ff.ch |=>
      te_ff[1] == $past(hwdata_in[C1_TE])
      && re_ff[0] == $past(re_ff[0]))
      else $error("enable write reached wrong channel");
   rdata_hold_a: assert property
      (!do_read |=> hrdata_ff == $past(hrdata_ff))
      else $error("read data changed without read");
   tb_write_a: assert property
      (do_write && sel_ff.kind == K_TB && sel_ff.ch |=>
      tb_ff[1] == $past(hwdata_in[RX_W-1:0]))
      else $error("transmit data not stored");
   err_clr_a: assert property
      (do_write && sel_ff.kind == K_C1 && !sel_ff.ch
      && !hwdata_in[C1_RE] && !eng_rx_done_in[0] |=>
      rb_word[0][RB_SUM:RB_OER] == 4'h0)
      else $error("receive disable kept errors");
   ri_read_a: assert property
      (do_read && sel_ff.kind == K_C1 && sel_ff.ch |=>
      hrdata_ff[C1_RI] == $past(full[1]))
      else $error("complete flag read wrong");
endmodule : sctrl_top

// [verification/sctrl_peer_model.sv]
`timescale 1ns/1ns
module sctrl_peer_model
   import sctrl_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] send_in,
   input wire logic [sctrl_pkg::RX_W-1:0] word_in,
   input wire logic bad_frame_in,
   input wire logic bad_par_in,
   input wire logic slow_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] tx_en_in,
   input wire logic [sctrl_pkg::SCTRL_CH-1:0] buf_empty_in,
   output logic [sctrl_pkg::SCTRL_CH-1:0] done_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0][sctrl_pkg::RX_W-1:0] data_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] frame_bad_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] par_bad_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] taken_out,
   output logic [sctrl_pkg::SCTRL_CH-1:0] idle_out
);
   logic [SCTRL_CH-1:0][4:0] busy_ff;
   // Outside a word the lines flip, so a stale value never looks valid
   always_ff @(posedge clk_sys_in)
   begin
      for (int c = 0; c < SCTRL_CH; c++)
      begin
         done_out[c] <= rst_n_in && send_in[c];
         data_out[c] <= send_in[c] ? word_in : ~data_out[c];
         frame_bad_out[c] <= send_in[c] ? bad_frame_in : ~frame_bad_out[c];
         par_bad_out[c] <= send_in[c] ? bad_par_in : ~par_bad_out[c];
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      for (int c = 0; c < SCTRL_CH; c++)
      begin
         taken_out[c] <= 1'b0;
         if (!rst_n_in)
         begin
            idle_out[c] <= 1'b1;
            busy_ff[c] <= 5'h0;
         end
         else if (busy_ff[c] != 5'h0)
         begin
            busy_ff[c] <= busy_ff[c] - 5'h1;
            idle_out[c] <= (busy_ff[c] == 5'h1);
         end
         else if (tx_en_in[c] && !buf_empty_in[c] && !taken_out[c])
         begin
            taken_out[c] <= 1'b1;
            idle_out[c] <= 1'b0;
            busy_ff[c] <= slow_in ? 5'h14 : 5'h4;
         end
      end
   end
endmodule : sctrl_peer_model

// [verification/serial_ctrl1_and_rx_buffer_tb.sv]
`timescale 1ns/1ns
module serial_ctrl1_and_rx_buffer_tb;
   import sctrl_pkg::*;
   logic clk_sys_in, rst_n_in, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [SCTRL_CH-1:0] rdone, fbad, pbad, taken, idle, ten, ren, crx;
   logic [SCTRL_CH-1:0] tbe, irq, send_v;
   logic [SCTRL_CH-1:0][RX_W-1:0] rdata, txd;
   logic [SCTRL_CH-1:0][2:0] smode;
   logic [RX_W-1:0] word;
   logic bad_f, bad_p, slow;
   int err_total, checks;
   int irq_cnt [SCTRL_CH];
   logic [9:0] i_c1 [SCTRL_CH] = '{IDX_C1_0, IDX_C1_1};
   logic [9:0] i_c0 [SCTRL_CH] = '{IDX_C0_0, IDX_C0_1};
   logic [9:0] i_rb [SCTRL_CH] = '{IDX_RB_0, IDX_RB_1};
   logic [9:0] i_tb [SCTRL_CH] = '{IDX_TB_0, IDX_TB_1};
   logic [9:0] i_mr [SCTRL_CH] = '{IDX_MR_0, IDX_MR_1};
   sctrl_top u_dut (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .hsel_in(hsel),
      .haddr_in(haddr),
      .htrans_in(htrans),
      .hwrite_in(hwrite),
      .hsize_in(3'h2),
      .hwdata_in(hwdata),
      .hready_in(hready),
      .hrdata_out(hrdata),
      .hreadyout_out(hready),
      .hresp_out(hresp),
      .eng_rx_done_in(rdone),
      .eng_rx_data_in(rdata),
      .eng_rx_fer_in(fbad),
      .eng_rx_per_in(pbad),
      .eng_tx_taken_in(taken),
      .eng_tx_shift_empty_in(idle),
      .tx_enable_out(ten),
      .rx_enable_out(ren),
      .cont_rx_out(crx),
      .serial_mode_out(smode),
      .tx_data_out(txd),
      .tx_buf_empty_out(tbe),
      .tx_irq_out(irq)
   );
   sctrl_peer_model u_peer (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .send_in(send_v),
      .word_in(word),
      .bad_frame_in(bad_f),
      .bad_par_in(bad_p),
      .slow_in(slow),
      .tx_en_in(ten),
      .buf_empty_in(tbe),
      .done_out(rdone),
      .data_out(rdata),
      .frame_bad_out(fbad),
      .par_bad_out(pbad),
      .taken_out(taken),
      .idle_out(idle)
   );
   initial
   begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in)
      for (int c = 0; c < SCTRL_CH; c++)
         if (irq[c] === 1'b1)
            irq_cnt[c]++;
   function automatic logic [31:0] c1x(input logic [7:0] w);
      return {24'h0, 2'h0, w[5:4], 1'b0, w[2], 1'b1, w[0]};
   endfunction : c1x
   function automatic logic [31:0] rbx(input logic [RX_W-1:0] d,
      input logic o, input logic f, input logic p);
      return {16'h0, o | f | p, p, f, o, 3'h0, d};
   endfunction : rbx
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // Master holds each phase until hready is sampled high
   task automatic bus(input logic wr, input logic [9:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, idx, 2'h0};
      @(posedge clk_sys_in);
      while (hready !== 1'b1 && n < 50)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_sys_in);
      while (hready !== 1'b1 && n < 50)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      if (n >= 50)
         err_total++;
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr
   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp,
      input string what);
      logic [31:0] v;
      bus(1'b0, idx, 32'h0, v);
      chk(what, v, exp);
   endtask : rdchk
   task automatic send(input int c, input logic [RX_W-1:0] w,
      input logic f, input logic p);
      send_v[c] <= 1'b1;
      word <= w;
      bad_f <= f;
      bad_p <= p;
      @(posedge clk_sys_in);
      send_v <= '0;
      @(posedge clk_sys_in);
   endtask : send
   task automatic wait_idle(input int c, input logic lvl);
      int n;
      n = 0;
      while (idle[c] !== lvl && n < 100)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      if (n >= 100)
         err_total++;
   endtask : wait_idle
   task automatic run_ch(input int c);
      logic [7:0] w;
      logic [RX_W-1:0] d, d2;
      logic f, p;
      slow <= (c == 0);
      rdchk(i_c1[c], 32'h02, "ctrl reset");
      chk("buf empty", 32'(tbe[c]), 32'h1);
      // Continuous receive only tried while the mode field is off
      repeat (6)
      begin
         w = 8'($urandom);
         wr(i_c1[c], {24'h0, w});
         rdchk(i_c1[c], c1x(w), "ctrl rw");
         chk("enables", {29'h0, crx[c], ren[c], ten[c]},
            {29'h0, w[5], w[2], w[0]});
      end
      wr(i_c1[c], 32'h0);
      $display("control test done on %0d", c);
      wr(i_mr[c], {29'h0, MODE_ASYNC8});
      rdchk(i_mr[c], {29'h0, MODE_ASYNC8}, "mode rw");
      chk("mode out", 32'(smode[c]), {29'h0, MODE_ASYNC8});
      d = RX_W'($urandom);
      wr(i_tb[c], {23'h0, d});
      rdchk(i_c1[c], 32'h00, "buf full flag");
      chk("tx data", 32'(txd[c]), 32'(d));
      irq_cnt[c] = 0;
      wr(i_c1[c], 32'h01);
      wait_idle(c, 1'b0);
      if (c == 0)
         rdchk(i_c0[c], 32'h00, "shift busy");
      wait_idle(c, 1'b1);
      rdchk(i_c0[c], 32'h08, "shift empty");
      chk("irq buf", irq_cnt[c], 32'h1);
      wr(i_c1[c], 32'h11);
      irq_cnt[c] = 0;
      wr(i_tb[c], {23'h0, ~d});
      wait_idle(c, 1'b0);
      wait_idle(c, 1'b1);
      rdchk(i_c1[c], 32'h13, "irq select");
      chk("irq shift", irq_cnt[c], 32'h1);
      $display("transmit test done on %0d", c);
      wr(i_c1[c], 32'h04);
      d = RX_W'($urandom);
      f = 1'($urandom);
      p = 1'($urandom);
      send(c, d, f, p);
      rdchk(i_c1[c], 32'h0E, "rx flag set");
      rdchk(i_rb[c], rbx(d, 1'b0, f, p), "rx word");
      rdchk(i_c1[c], 32'h06, "rx flag clear");
      rdchk(i_rb[c], rbx(d, 1'b0, 1'b0, 1'b0), "read clear");
      d2 = ~d;
      send(c, d, 1'b1, 1'b0);
      send(c, d2, 1'b0, 1'b0);
      rdchk(i_rb[c], rbx(d, 1'b1, 1'b1, 1'b0), "overrun");
      rdchk(i_rb[c], rbx(d, 1'b1, 1'b0, 1'b0), "overrun stays");
      wr(i_c1[c], 32'h0);
      rdchk(i_rb[c], rbx(d, 1'b0, 1'b0, 1'b0), "rx off clear");
      wr(i_c1[c], 32'h04);
      send(c, d2, 1'b1, 1'b0);
      send(c, d, 1'b0, 1'b0);
      wr(i_mr[c], {29'h0, MODE_OFF});
      rdchk(i_rb[c], rbx(d2, 1'b0, 1'b0, 1'b0), "mode clear");
      wr(i_mr[c], {29'h0, MODE_SYNC});
      send(c, d, 1'b1, 1'b1);
      rdchk(i_rb[c], rbx(d, 1'b0, 1'b0, 1'b0), "sync mask");
      wr(i_mr[c], {29'h0, MODE_OFF});
      wr(i_c1[c], 32'h0);
      $display("receive test done on %0d", c);
   endtask : run_ch
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      err_total++;
      report_and_stop;
   end
   initial
   begin
      rst_n_in = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      send_v = '0;
      word = '0;
      bad_f = 1'b0;
      bad_p = 1'b0;
      slow = 1'b0;
      err_total = 0;
      checks = 0;
      void'($urandom(5942));
      repeat (16) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      for (int c = 0; c < SCTRL_CH; c++)
         run_ch(c);
      wr(10'h3FF, 32'hFFFFFFFF);
      rdchk(10'h3FF, 32'h0, "unmapped");
      chk("response", 32'(hresp), 32'h0);
      $display("unmapped test done");
      report_and_stop;
   end
endmodule : serial_ctrl1_and_rx_buffer_tb
